// File: src/ufd_consts.svh
/*
 Offsets, field positions, reset values and sizes of the UART DMA block.
 Assumes a 32-bit register address decoded in full.
*/
`ifndef UFD_CONSTS_SVH
`define UFD_CONSTS_SVH
`define UFD_A_TXBEGA 32'h4000C800
`define UFD_A_TXENDA 32'h4000C804
`define UFD_A_TXBEGB 32'h4000C808
`define UFD_A_TXENDB 32'h4000C80C
`define UFD_A_RXBEGA 32'h4000C810
`define UFD_A_RXENDA 32'h4000C814
`define UFD_A_RXBEGB 32'h4000C818
`define UFD_A_RXENDB 32'h4000C81C
`define UFD_A_TXCNT 32'h4000C820
`define UFD_A_RXCNTA 32'h4000C824
`define UFD_A_RXCNTB 32'h4000C828
`define UFD_A_DMASTAT 32'h4000C82C
`define UFD_A_DMACTRL 32'h4000C830
`define UFD_A_STAT 32'h4000C848
`define UFD_A_CFG 32'h4000C85C
`define UFD_A_PER 32'h4000C868
`define UFD_A_FRAC 32'h4000C86C
`define UFD_C_TXRST 5
`define UFD_C_RXRST 4
`define UFD_C_TXLD 3:2
`define UFD_C_RXLD 1:0
`define UFD_S_TXIDLE 6
`define UFD_S_PERR 5
`define UFD_S_FERR 4
`define UFD_S_TXFREE 2
`define UFD_S_RXVAL 1
`define UFD_S_CTS 0
`define UFD_CFG_W 7
`define UFD_RST_CFG 7'h00
`define UFD_RST_PER 16'h0000
`define UFD_RST_FRAC 1'h0
`define UFD_MAW 16
`define UFD_FRW 12
`endif

// File: src/ufd_pkg.sv
/*
 Types of the UART DMA block.
 Assumes ufd_consts.svh is on the include path.
*/
`include "ufd_consts.svh"
package ufd_pkg;
    typedef struct packed {
        logic auto_rts_enable;
        logic flow_ctrl_enable;
        logic odd_parity_select;
        logic parity_enable;
        logic two_stop_select;
        logic eight_bit_select;
        logic manual_rts_level;
    } ufd_cfg_t;
    typedef struct packed {
        logic we;
        logic re;
        logic [`UFD_MAW-1:0] addr;
        logic [7:0] wdata;
    } ufd_mem_t;
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} ufd_txs_t;
    typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100} ufd_rxs_t;
endpackage : ufd_pkg

// File: src/ufd_uart_dma.sv
/*
 UART framing, baud generator, RTS/CTS and ping-pong DMA channels.
 Assumes one clock, a memory port answering reads one cycle after
 the request, and pins that are asynchronous to clk_sys.
*/
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ufd_consts.svh"
module ufd_uart_dma import ufd_pkg::*; #(
    parameter int RXF_DEPTH = 4,
    parameter int RXF_AW = 2
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output ufd_mem_t mem_req,
    input wire logic [7:0] mem_rdata,
    input wire logic rxd,
    input wire logic cts_n,
    output logic txd,
    output logic rts_n
);
    localparam int MAW = `UFD_MAW;
    localparam int FRW = `UFD_FRW;

    function automatic logic over(input logic [MAW-1:0] b, input logic [MAW-1:0] c,
                                  input logic [MAW-1:0] e);
        logic [MAW:0] s;
        s = {1'b0, b} + {1'b0, c};
        return s > {1'b0, e};
    endfunction : over

    // Frame bits LSB first in low part, length in top nibble
    function automatic logic [FRW+3:0] frame(input logic [7:0] d, input ufd_cfg_t c);
        logic [FRW-1:0] f;
        logic [3:0] n;
        logic p;
        f = '1;
        f[0] = 1'b0;
        n = c.eight_bit_select ? 4'h8 : 4'h7;
        p = c.odd_parity_select;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(n)) begin
                f[i+1] = d[i];
                p = p ^ d[i];
            end
        end
        if (c.parity_enable)
            f[n+4'h1] = p;
        return {4'h1 + n + {3'h0, c.parity_enable} + 4'h1 + {3'h0, c.two_stop_select}, f};
    endfunction : frame

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] rxd_sync_ff;
    logic [1:0] cts_sync_ff;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxd_sync_ff <= 2'h3;
            cts_sync_ff <= 2'h3;
        end else begin
            rxd_sync_ff <= {rxd_sync_ff[0], rxd};
            cts_sync_ff <= {cts_sync_ff[0], cts_n};
        end
    end
    logic rx_in;
    logic cts_ok;
    assign rx_in = rxd_sync_ff[1];
    assign cts_ok = !cts_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////
    ufd_cfg_t cfg_ff;
    logic [15:0] per_ff;
    logic frac_ff;
    logic [MAW-1:0] tx_beg_ff [2];
    logic [MAW-1:0] tx_end_ff [2];
    logic [MAW-1:0] rx_beg_ff [2];
    logic [MAW-1:0] rx_end_ff [2];
    logic [MAW-1:0] wmaw;
    assign wmaw = reg_wdata[MAW-1:0];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= `UFD_RST_CFG;
            per_ff <= `UFD_RST_PER;
            frac_ff <= `UFD_RST_FRAC;
        end else if (reg_wr) begin
            if (reg_addr == `UFD_A_CFG)
                cfg_ff <= ufd_cfg_t'(reg_wdata[`UFD_CFG_W-1:0]);
            if (reg_addr == `UFD_A_PER)
                per_ff <= reg_wdata[15:0];
            if (reg_addr == `UFD_A_FRAC)
                frac_ff <= reg_wdata[0];
        end
    end

    // Ends accepted any time, so a live transfer sees them at once
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2; i++) begin
                tx_beg_ff[i] <= '0;
                tx_end_ff[i] <= '0;
                rx_beg_ff[i] <= '0;
                rx_end_ff[i] <= '0;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                `UFD_A_TXBEGA: tx_beg_ff[0] <= wmaw;
                `UFD_A_TXENDA: tx_end_ff[0] <= wmaw;
                `UFD_A_TXBEGB: tx_beg_ff[1] <= wmaw;
                `UFD_A_TXENDB: tx_end_ff[1] <= wmaw;
                `UFD_A_RXBEGA: rx_beg_ff[0] <= wmaw;
                `UFD_A_RXENDA: rx_end_ff[0] <= wmaw;
                `UFD_A_RXBEGB: rx_beg_ff[1] <= wmaw;
                `UFD_A_RXENDB: rx_end_ff[1] <= wmaw;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic ctl_wr;
    logic tx_rst;
    logic rx_rst;
    logic [1:0] tx_load;
    logic [1:0] rx_cwr;
    logic [1:0] rx_load;
    assign ctl_wr = reg_wr && reg_addr == `UFD_A_DMACTRL;
    assign tx_rst = ctl_wr && reg_wdata[`UFD_C_TXRST];
    assign rx_rst = ctl_wr && reg_wdata[`UFD_C_RXRST];
    assign tx_load = ctl_wr ? reg_wdata[`UFD_C_TXLD] : 2'h0;
    assign rx_cwr = {reg_wr && reg_addr == `UFD_A_RXCNTB, reg_wr && reg_addr == `UFD_A_RXCNTA};

    logic [1:0] tx_ld_ff;
    logic tx_sel_ff;
    logic [MAW-1:0] tx_cnt_ff;
    logic [1:0] tx_pend_ff;
    logic [7:0] tx_hold_ff;
    logic tx_hold_v_ff;
    logic tx_act;
    logic tx_over;
    logic tx_go;
    logic tx_start;
    logic [1:0] rx_ld_ff;
    logic rx_sel_ff;
    logic [MAW-1:0] rx_cnt_ff [2];
    logic [1:0] rx_over;
    logic rx_act;
    logic rx_go;
    logic rxf_ne;
    logic [7:0] rxf_head;

    assign tx_act = tx_ld_ff[tx_sel_ff];
    assign tx_over = over(tx_beg_ff[tx_sel_ff], tx_cnt_ff, tx_end_ff[tx_sel_ff]);
    assign rx_over[0] = over(rx_beg_ff[0], rx_cnt_ff[0], rx_end_ff[0]);
    assign rx_over[1] = over(rx_beg_ff[1], rx_cnt_ff[1], rx_end_ff[1]);
    assign rx_act = rx_ld_ff[rx_sel_ff];
    assign rx_load = (ctl_wr ? reg_wdata[`UFD_C_RXLD] : 2'h0) | (rx_cwr & ~rx_ld_ff);
    assign rx_go = rx_act && !rx_over[rx_sel_ff] && rxf_ne;
    // Receive wins the memory port; the FIFO is the side that overflows
    assign tx_go = tx_act && !tx_over && !tx_hold_v_ff && tx_pend_ff == 2'h0 && !rx_go;

    // Load wins over unload in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            tx_ld_ff <= 2'h0;
        else if (tx_rst)
            tx_ld_ff <= 2'h0;
        else
            tx_ld_ff <= (tx_ld_ff & ~({1'b0, tx_act && tx_over} << tx_sel_ff)) | tx_load;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            tx_sel_ff <= 1'b0;
        else if (tx_rst)
            tx_sel_ff <= 1'b0;
        else if (!tx_act)
            // Incoming loads count too, so a stale B select never beats a fresh A
            tx_sel_ff <= !(tx_ld_ff[0] || tx_load[0]) && (tx_ld_ff[1] || tx_load[1] || tx_sel_ff);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            tx_cnt_ff <= '0;
        else if (tx_rst || (!tx_act && (tx_load != 2'h0 || tx_ld_ff != 2'h0)))
            tx_cnt_ff <= '0;
        else if (tx_go)
            tx_cnt_ff <= tx_cnt_ff + 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_pend_ff <= 2'h0;
            tx_hold_ff <= 8'h00;
            tx_hold_v_ff <= 1'b0;
        end else begin
            tx_pend_ff <= {tx_pend_ff[0], tx_go};
            if (tx_pend_ff[1]) begin
                tx_hold_ff <= mem_rdata;
                tx_hold_v_ff <= 1'b1;
            end else if (tx_start || tx_rst)
                tx_hold_v_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            rx_ld_ff <= 2'h0;
        else if (rx_rst)
            rx_ld_ff <= 2'h0;
        else
            rx_ld_ff <= (rx_ld_ff & ~rx_over) | rx_load;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            rx_sel_ff <= 1'b0;
        else if (rx_rst)
            rx_sel_ff <= 1'b0;
        else if (!rx_act)
            rx_sel_ff <= !(rx_ld_ff[0] || rx_load[0]) && (rx_ld_ff[1] || rx_load[1] || rx_sel_ff);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_ff[0] <= '0;
            rx_cnt_ff[1] <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (rx_rst)
                    rx_cnt_ff[i] <= '0;
                else if (rx_cwr[i])
                    rx_cnt_ff[i] <= wmaw;
                else if (rx_load[i])
                    rx_cnt_ff[i] <= '0;
                else if (rx_go && rx_sel_ff == 1'(i))
                    rx_cnt_ff[i] <= rx_cnt_ff[i] + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            mem_req <= '0;
        else begin
            mem_req.we <= rx_go;
            mem_req.re <= tx_go;
            mem_req.addr <= rx_go ? rx_beg_ff[rx_sel_ff] + rx_cnt_ff[rx_sel_ff]
                                  : tx_beg_ff[tx_sel_ff] + tx_cnt_ff;
            mem_req.wdata <= rxf_head;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [16:0] bit_len;
    assign bit_len = ({per_ff, 1'b0} + {16'h0000, frac_ff} < 17'h00002) ? 17'h00002
                   : {per_ff, 1'b0} + {16'h0000, frac_ff};

    ufd_txs_t tx_st_ff;
    logic [FRW-1:0] tx_fr_ff;
    logic [3:0] tx_left_ff;
    logic [16:0] tx_tick_ff;
    logic [FRW+3:0] tx_next;
    assign tx_next = frame(tx_hold_ff, cfg_ff);
    assign tx_start = tx_st_ff == TX_IDLE && tx_hold_v_ff &&
                      (!cfg_ff.flow_ctrl_enable || cts_ok);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_st_ff <= TX_IDLE;
            tx_fr_ff <= '1;
            tx_left_ff <= 4'h0;
            tx_tick_ff <= '0;
            txd <= 1'b1;
        end else begin
            case (tx_st_ff)
                TX_IDLE: begin
                    if (tx_start) begin
                        tx_st_ff <= TX_SEND;
                        tx_fr_ff <= tx_next[FRW-1:0];
                        tx_left_ff <= tx_next[FRW+3:FRW];
                        tx_tick_ff <= '0;
                        txd <= 1'b0;
                    end
                end
                TX_SEND: begin
                    if (tx_tick_ff == bit_len - 17'h00001) begin
                        tx_tick_ff <= '0;
                        tx_fr_ff <= {1'b1, tx_fr_ff[FRW-1:1]};
                        tx_left_ff <= tx_left_ff - 4'h1;
                        txd <= tx_left_ff == 4'h1 ? 1'b1 : tx_fr_ff[1];
                        if (tx_left_ff == 4'h1)
                            tx_st_ff <= TX_IDLE;
                    end else
                        tx_tick_ff <= tx_tick_ff + 17'h00001;
                end
                default: tx_st_ff <= TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    ufd_rxs_t rx_st_ff;
    logic [16:0] rx_tick_ff;
    logic [3:0] rx_idx_ff;
    logic [10:0] rx_bits_ff;
    logic rx_done_ff;
    logic [3:0] rx_n;
    logic [3:0] rx_last;
    assign rx_n = cfg_ff.eight_bit_select ? 4'h8 : 4'h7;
    assign rx_last = rx_n + {3'h0, cfg_ff.parity_enable};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_ff <= RX_IDLE;
            rx_tick_ff <= '0;
            rx_idx_ff <= 4'h0;
            rx_bits_ff <= '0;
            rx_done_ff <= 1'b0;
        end else begin
            rx_done_ff <= 1'b0;
            case (rx_st_ff)
                RX_IDLE: begin
                    rx_tick_ff <= '0;
                    rx_idx_ff <= 4'h0;
                    if (!rx_in)
                        rx_st_ff <= RX_START;
                end
                RX_START: begin
                    // Mid-bit recheck rejects short glitches
                    if (rx_tick_ff == {1'b0, bit_len[16:1]} - 17'h00001) begin
                        rx_tick_ff <= '0;
                        rx_st_ff <= rx_in ? RX_IDLE : RX_DATA;
                    end else
                        rx_tick_ff <= rx_tick_ff + 17'h00001;
                end
                RX_DATA: begin
                    if (rx_tick_ff == bit_len - 17'h00001) begin
                        rx_tick_ff <= '0;
                        rx_bits_ff[rx_idx_ff] <= rx_in;
                        rx_idx_ff <= rx_idx_ff + 4'h1;
                        if (rx_idx_ff == rx_last) begin
                            rx_st_ff <= RX_IDLE;
                            rx_done_ff <= 1'b1;
                        end
                    end else
                        rx_tick_ff <= rx_tick_ff + 17'h00001;
                end
                default: rx_st_ff <= RX_IDLE;
            endcase
        end
    end

    logic [7:0] rx_byte;
    logic rx_perr;
    logic rx_ferr;
    assign rx_byte = cfg_ff.eight_bit_select ? rx_bits_ff[7:0] : {1'b0, rx_bits_ff[6:0]};
    assign rx_perr = cfg_ff.parity_enable &&
                     ((^rx_byte) ^ rx_bits_ff[rx_n] ^ cfg_ff.odd_parity_select);
    assign rx_ferr = !rx_bits_ff[rx_last];

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] rxf_mem [RXF_DEPTH];
    logic [RXF_AW-1:0] rxf_wp_ff;
    logic [RXF_AW-1:0] rxf_rp_ff;
    logic [RXF_AW:0] rxf_cnt_ff;
    logic [RXF_AW:0] rxf_free;
    logic rxf_push;
    assign rxf_free = (RXF_AW+1)'(RXF_DEPTH) - rxf_cnt_ff;
    assign rxf_push = rx_done_ff && rxf_free != '0;
    assign rxf_ne = rxf_cnt_ff != '0;
    assign rxf_head = rxf_mem[rxf_rp_ff];

    always_ff @(posedge clk_sys) begin
        if (rxf_push)
            rxf_mem[rxf_wp_ff] <= rx_byte;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxf_wp_ff <= '0;
            rxf_rp_ff <= '0;
            rxf_cnt_ff <= '0;
        end else begin
            if (rxf_push)
                rxf_wp_ff <= rxf_wp_ff + 1'b1;
            if (rx_go)
                rxf_rp_ff <= rxf_rp_ff + 1'b1;
            rxf_cnt_ff <= rxf_cnt_ff + {{RXF_AW{1'b0}}, rxf_push} - {{RXF_AW{1'b0}}, rx_go};
        end
    end

    // Flow disabled leaves RTS asserted
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            rts_n <= 1'b0;
        else if (!cfg_ff.flow_ctrl_enable)
            rts_n <= 1'b0;
        else if (cfg_ff.auto_rts_enable)
            rts_n <= rxf_free <= (RXF_AW+1)'(1);
        else
            rts_n <= !cfg_ff.manual_rts_level;
    end

    ////////////////////////////////////////////////////////////////////////
    logic perr_ff;
    logic ferr_ff;
    logic stat_rd;
    assign stat_rd = reg_rd && reg_addr == `UFD_A_STAT;
    // Set wins over the read that clears
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            perr_ff <= 1'b0;
            ferr_ff <= 1'b0;
        end else begin
            perr_ff <= (rx_done_ff && rx_perr) || (perr_ff && !stat_rd);
            ferr_ff <= (rx_done_ff && rx_ferr) || (ferr_ff && !stat_rd);
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        case (reg_addr)
            `UFD_A_TXBEGA: rd_mux[MAW-1:0] = tx_beg_ff[0];
            `UFD_A_TXENDA: rd_mux[MAW-1:0] = tx_end_ff[0];
            `UFD_A_TXBEGB: rd_mux[MAW-1:0] = tx_beg_ff[1];
            `UFD_A_TXENDB: rd_mux[MAW-1:0] = tx_end_ff[1];
            `UFD_A_RXBEGA: rd_mux[MAW-1:0] = rx_beg_ff[0];
            `UFD_A_RXENDA: rd_mux[MAW-1:0] = rx_end_ff[0];
            `UFD_A_RXBEGB: rd_mux[MAW-1:0] = rx_beg_ff[1];
            `UFD_A_RXENDB: rd_mux[MAW-1:0] = rx_end_ff[1];
            `UFD_A_TXCNT: rd_mux[MAW-1:0] = tx_cnt_ff;
            `UFD_A_RXCNTA: rd_mux[MAW-1:0] = rx_cnt_ff[0];
            `UFD_A_RXCNTB: rd_mux[MAW-1:0] = rx_cnt_ff[1];
            `UFD_A_DMASTAT: rd_mux[3:0] = {tx_ld_ff, rx_ld_ff};
            `UFD_A_DMACTRL: rd_mux[3:0] = {tx_ld_ff, rx_ld_ff};
            `UFD_A_STAT: begin
                rd_mux[`UFD_S_TXIDLE] = tx_st_ff == TX_IDLE && !tx_hold_v_ff && tx_pend_ff == 2'h0;
                rd_mux[`UFD_S_PERR] = perr_ff;
                rd_mux[`UFD_S_FERR] = ferr_ff;
                rd_mux[`UFD_S_TXFREE] = !tx_hold_v_ff;
                rd_mux[`UFD_S_RXVAL] = rxf_ne;
                rd_mux[`UFD_S_CTS] = cts_ok;
            end
            `UFD_A_CFG: rd_mux[`UFD_CFG_W-1:0] = cfg_ff;
            `UFD_A_PER: rd_mux[15:0] = per_ff;
            `UFD_A_FRAC: rd_mux[0] = frac_ff;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= 32'h00000000;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence tx_begin_s;
        tx_start ##1 !txd;
    endsequence

    rts_auto_a: assert property (cfg_ff.flow_ctrl_enable && cfg_ff.auto_rts_enable
        |=> rts_n == $past(rxf_free <= (RXF_AW+1)'(1))) else $error("auto rts wrong");
    rts_manual_a: assert property (cfg_ff.flow_ctrl_enable && !cfg_ff.auto_rts_enable
        |=> rts_n == !$past(cfg_ff.manual_rts_level)) else $error("manual rts wrong");
    cts_block_a: assert property (cfg_ff.flow_ctrl_enable && cts_sync_ff[1] && tx_st_ff == TX_IDLE
        |=> txd) else $error("sent while cts off");
    no_flow_a: assert property (!cfg_ff.flow_ctrl_enable && tx_st_ff == TX_IDLE
        && tx_hold_v_ff |-> tx_begin_s) else $error("cts held transmitter");
    tx_len_a: assert property (tx_start |=> tx_left_ff == 4'h2
        + $past(rx_n) + $past({3'h0, cfg_ff.parity_enable}) + $past({3'h0, cfg_ff.two_stop_select}))
        else $error("frame length wrong");
    a_first_a: assert property (rx_ld_ff == 2'h3 && $past(rx_ld_ff) == 2'h0
        |=> !rx_sel_ff) else $error("buffer b taken first");
    tx_first_a: assert property (tx_ld_ff == 2'h3 && $past(tx_ld_ff) == 2'h0
        |-> !tx_sel_ff) else $error("tx buffer b taken first");
    rx_unload_a: assert property (rx_ld_ff[0] && rx_over[0] && !rx_rst
        |=> !rx_ld_ff[0] || $past(rx_load[0])) else $error("no unload");
    cnt_keep_a: assert property (!rx_ld_ff[0] && !rx_load[0] && !rx_rst && !rx_cwr[0]
        |=> $stable(rx_cnt_ff[0])) else $error("count lost");
    bit_time_a: assert property (tx_st_ff == TX_SEND |-> tx_tick_ff < bit_len)
        else $error("bit timer overran");
    wr_addr_a: assert property (rx_go ##1 mem_req.we |-> mem_req.addr
        == $past(rx_beg_ff[rx_sel_ff]) + $past(rx_cnt_ff[rx_sel_ff])) else $error("dma address wrong");
endmodule : ufd_uart_dma
`default_nettype wire

// File: verif/ufd_remote.sv
/*
 Remote serial device: sends frames on rxd, captures frames from txd.
 Assumes the bench sets bt, the bit time in clk_sys cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module ufd_remote (
    input wire logic clk_sys,
    input wire logic txd,
    output logic rxd
);
    int bt = 2;
    initial rxd = 1'b1;
    // Line idles high once the last stop bit is out
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            rxd <= f[i];
            repeat (bt - 1) @(posedge clk_sys);
        end
    endtask : send
    // Mid-bit sampling tolerates a cycle of skew on the start edge
    task automatic grab(output logic [11:0] f, input int n);
        int w = 0;
        f = '1;
        while (txd !== 1'b0 && w < 9000) begin
            @(negedge clk_sys);
            w++;
        end
        repeat (bt / 2) @(negedge clk_sys);
        for (int i = 0; i < n; i++) begin
            if (i > 0) repeat (bt) @(negedge clk_sys);
            f[i] = txd;
        end
    endtask : grab
endmodule : ufd_remote
`default_nettype wire

// File: verif/testbench.sv
/*
 Self-checking bench of the UART DMA block with a byte memory model.
 Assumes ufd_consts.svh on the include path and ufd_pkg compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ufd_consts.svh"
module testbench import ufd_pkg::*; ;
    logic clk_sys, rst_n, reg_wr, reg_rd, cts_n, rxd, txd, rts_n, lo;
    logic [31:0] reg_addr, reg_wdata, reg_rdata, rv;
    ufd_mem_t mem_req;
    logic [7:0] mem_rdata = 8'h00, wr_data;
    logic [7:0] mem [16];
    logic [15:0] wr_addr;
    logic [11:0] f, g;
    logic [7:0] rcfg [4] = '{8'h01, 8'h21, 8'h20, 8'h60};
    logic rexp [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    int num_errors = 0, num_checks = 0, cyc = 0, wr_cnt = 0, n, bt, per, fr;
    ufd_cfg_t cf;
    ufd_uart_dma i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n));
    ufd_remote i_rem (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Idle read data toggles so a stale byte never matches
    always @(posedge clk_sys) begin
        mem_rdata <= mem_req.re ? mem[mem_req.addr[3:0]] : ~mem_rdata;
        if (mem_req.we) begin
            wr_addr <= mem_req.addr;
            wr_data <= mem_req.wdata;
            wr_cnt <= wr_cnt + 1;
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (num_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, exp);
    endtask : rc
    function automatic logic [11:0] frame(input logic [7:0] d, input ufd_cfg_t c, output int n);
        logic [7:0] v;
        v = c.eight_bit_select ? d : {1'b0, d[6:0]};
        frame = '1;
        frame[0] = 1'b0;
        n = c.eight_bit_select ? 9 : 8;
        for (int i = 0; i < n - 1; i++) frame[i + 1] = v[i];
        if (c.parity_enable) begin
            frame[n] = ^v ^ c.odd_parity_select;
            n++;
        end
        n = n + 1 + int'(c.two_stop_select);
    endfunction : frame
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, cts_n} = {66'h0, 1'b1};
        void'($urandom(87));
        for (int i = 0; i < 16; i++) mem[i] = 8'($urandom);
        per = 4 + $urandom % 3;
        fr = $urandom % 2;
        bt = 2 * per + fr;
        i_rem.bt = bt;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rc(`UFD_A_CFG, 0);
        rc(`UFD_A_PER, 0);
        rc(`UFD_A_FRAC, 0);
        rc(32'h4000C8F0, 0);
        wr(`UFD_A_PER, 32'(per));
        wr(`UFD_A_FRAC, 32'(fr));
        rc(`UFD_A_PER, 32'(per));
        rc(`UFD_A_FRAC, 32'(fr));
        for (int i = 0; i < 4; i++) begin
            wr(`UFD_A_CFG, 32'(rcfg[i]));
            repeat (2) @(negedge clk_sys);
            chk(32'(rts_n), 32'(rexp[i]));
        end
        wr(`UFD_A_DMACTRL, 32'h30);
        // Flow off with CTS high: transmitter must not stall
        for (int k = 0; k < 3; k++) begin
            cf = ufd_cfg_t'(7'($urandom) & 7'h1E);
            wr(`UFD_A_CFG, 32'(cf));
            wr(`UFD_A_TXBEGA, 32'(2 * k));
            wr(`UFD_A_TXENDA, 32'(2 * k));
            wr(`UFD_A_TXBEGB, 32'(2 * k + 1));
            wr(`UFD_A_TXENDB, 32'(2 * k + 1));
            wr(`UFD_A_DMACTRL, 32'h0C);
            for (int j = 0; j < 2; j++) begin
                f = frame(mem[2 * k + j], cf, n);
                i_rem.grab(g, n);
                chk(32'(g), 32'(f));
            end
            rc(`UFD_A_DMACTRL, 0);
            rc(`UFD_A_TXCNT, 1);
            repeat (bt) @(posedge clk_sys);
        end
        wr(`UFD_A_CFG, 32'h22);
        wr(`UFD_A_TXBEGA, 6);
        wr(`UFD_A_TXENDA, 6);
        wr(`UFD_A_DMACTRL, 32'h04);
        lo = 1'b0;
        repeat (8 * bt) begin
            @(negedge clk_sys);
            if (txd !== 1'b1) lo = 1'b1;
        end
        chk(32'(lo), 0);
        @(posedge clk_sys);
        cts_n <= 1'b0;
        f = frame(mem[6], ufd_cfg_t'(7'h22), n);
        i_rem.grab(g, n);
        chk(32'(g), 32'(f));
        repeat (bt) @(posedge clk_sys);
        cf = ufd_cfg_t'(7'h02 | (7'($urandom) & 7'h1C));
        wr(`UFD_A_CFG, 32'(cf));
        wr(`UFD_A_DMACTRL, 32'h10);
        wr(`UFD_A_RXBEGA, 8);
        wr(`UFD_A_RXENDA, 8);
        wr(`UFD_A_DMACTRL, 32'h01);
        f = frame(mem[9], cf, n);
        i_rem.send(f, n);
        for (int w = 0; w < 300 && wr_cnt == 0; w++) @(negedge clk_sys);
        chk(32'(wr_addr), 8);
        chk(32'(wr_data), 32'(mem[9]));
        rc(`UFD_A_DMACTRL, 0);
        rc(`UFD_A_RXCNTA, 1);
        wr(`UFD_A_RXBEGB, 0);
        wr(`UFD_A_RXENDB, 32'h20);
        wr(`UFD_A_RXCNTB, 3);
        rc(`UFD_A_DMACTRL, 2);
        rc(`UFD_A_RXCNTB, 3);
        wr(`UFD_A_RXENDB, 2);
        rc(`UFD_A_DMACTRL, 0);
        // No buffer loaded: three bytes leave room for one, so RTS drops
        wr(`UFD_A_CFG, 32'h62);
        f = frame(8'h5A, ufd_cfg_t'(7'h62), n);
        repeat (3) i_rem.send(f, n);
        repeat (bt) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(32'(rts_n), 1);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
